// file: rtseq_top.sv
`timescale 1ns/100ps
`include "rtseq_consts.svh"
// Overview of operation
// - drive oscillator divided by four on clock out pin in rc/internal clock_out_pin modes
// - report seven reset causes: power-on, watchdog run/sleep/wake, clear run/sleep, brown-out
// - undefined-state registers keep contents across every later reset
// - reset-state registers load on all resets except watchdog wake from sleep
// - timeout and powerdown flags take a cause-dependent pattern
// - clear pin input is glitch filtered before it can reset
// - watchdog reset never drives the clear pin low
// - internal clear option ties clear inactive; no pull-up on the pin
// - power-on holds reset until supply good; no reset on later supply fall
// - power-up timer gives 72 ms, only after power-on or brown-out
// - power-up timer disabled by config bit one, enabled by zero
// - crystal start-up counts 1024 oscillator cycles after power-up delay
// - start-up count only in crystal modes, only on power-on or sleep wake
// - brown-out detect enabled by config bit one, disabled by zero
// - brown-out resets once low supply persists past minimum duration
// - after brown-out wait for supply above release, then optional 72 ms
// - brown-out does not start power-up timer when it is disabled
// - low supply during power-up timer re-enters brown-out and restarts timer
// - power-up delay then start-up count, only enabled stages applied
// - external clock with timer disabled gives no start-up delay
// - delays run from power-on regardless of clear; release then starts at once
// - power-on flag cleared by power-on reset, else unchanged; software sets it
// - brown-out flag cleared by brown-out reset; software sets it
module rtseq_top #(
  parameter int POWERUP_DELAY_TIMER_CYCLES = (`RTSEQ_CLK_HZ / 1000) * `RTSEQ_POWERUP_DELAY_TIMER_MS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // supply monitor and pins
  input wire logic supply_ok,
  input wire logic brownout_detect,
  input wire logic ext_clear_pin,
  input wire logic osc_in_tick,
  // core side events
  input wire logic watchdog_timer,
  input wire logic core_sleeping,
  // configuration
  input rtseq_pkg::rtseq_cfg_t cfg,
  // software writes to the flags
  input wire logic sw_set_por_flag,
  input wire logic sw_set_bod_flag,
  // outputs
  output logic core_reset,
  output logic regs_reset_load,
  output logic wake_from_sleep,
  output rtseq_pkg::rtseq_cause_t reset_cause,
  output rtseq_pkg::rtseq_flags_t status_flags,
  output logic clock_out_pin,
  output logic clock_out_pin_oe,
  output logic ext_clear_pin_oe
);
  import rtseq_pkg::*;

  localparam logic [21:0] POWERUP_DELAY_TIMER_LAST = 22'(POWERUP_DELAY_TIMER_CYCLES - 1);
  localparam logic [21:0] OST_LAST = 22'(`RTSEQ_OST_CYCLES - 1);
  localparam logic [3:0] FILT_MAX = 4'(`RTSEQ_CLR_FILT_CYC);
  localparam logic [5:0] BOD_MAX = 6'(`RTSEQ_BOD_MIN_CYC);

  rtseq_st_t q, d;

  // crystal modes need the start-up count
  function automatic logic is_crystal(input logic [2:0] m);
    is_crystal = (m == `RTSEQ_OSC_LP) || (m == `RTSEQ_OSC_XT) || (m == `RTSEQ_OSC_HS);
  endfunction : is_crystal

  // modes that may drive the divided clock out
  function automatic logic is_clock_out_pin(input logic [2:0] m);
    is_clock_out_pin = (m == `RTSEQ_OSC_INT_CK) || (m == `RTSEQ_OSC_RC_CK);
  endfunction : is_clock_out_pin

  logic clr_active;
  logic bod_trip;
  logic wdt_any;

  // next-state logic
  always_comb begin
    d = q;
    d.regs_load = 1'b0;
    d.wake_pulse = 1'b0;

    // filter needs several stable low samples; short pulses only reload it
    if (cfg.ext_clear_pin_select && !ext_clear_pin) begin
      if (q.clr_filt != FILT_MAX) begin
        d.clr_filt = q.clr_filt + 4'h1;
      end
    end else begin
      d.clr_filt = 4'h0;
    end
    d.clr_low = (d.clr_filt == FILT_MAX);
    clr_active = q.clr_low;

    // brown-out needs the low indication to persist
    if (cfg.brownout_enable_cfg && brownout_detect) begin
      if (q.bod_cnt != BOD_MAX) begin
        d.bod_cnt = q.bod_cnt + 6'h01;
      end
    end else begin
      d.bod_cnt = 6'h00;
    end
    bod_trip = (q.bod_cnt == BOD_MAX);
    wdt_any = watchdog_timer;

    // divided clock on the shared pin: top count bit gives clk/4, masked in the flop
    // so the pin itself comes straight from a register
    d.div = q.div + 2'h1;
    d.clk_out = d.div[1] & is_clock_out_pin(cfg.osc_mode);
    d.clk_out_oe = is_clock_out_pin(cfg.osc_mode);

    case (q.state)
      RTSEQ_S_HOLD: begin
        d.core_rst = 1'b1;
        d.cnt = 22'h00_0000;
        // wait for supply and no pending brown-out
        if (supply_ok && !bod_trip) begin
          if (q.powerup_delay_timer_pend && !cfg.powerup_delay_off_cfg) begin
            d.state = RTSEQ_S_POWERUP_DELAY_TIMER;
          end else if (q.ost_pend && is_crystal(cfg.osc_mode)) begin
            d.state = RTSEQ_S_OST;
          end else begin
            d.state = RTSEQ_S_WAITCLR;
          end
        end
      end
      RTSEQ_S_POWERUP_DELAY_TIMER: begin
        d.cnt = q.cnt + 22'h00_0001;
        if (bod_trip || !supply_ok) begin
          d.state = RTSEQ_S_HOLD;
          d.in_bod = 1'b1;
        end else if (q.cnt == POWERUP_DELAY_TIMER_LAST) begin
          d.cnt = 22'h00_0000;
          d.powerup_delay_timer_pend = 1'b0;
          if (q.ost_pend && is_crystal(cfg.osc_mode)) begin
            d.state = RTSEQ_S_OST;
          end else begin
            d.state = RTSEQ_S_WAITCLR;
          end
        end
      end
      RTSEQ_S_OST: begin
        // counts the primary oscillator, not the system clock
        if (osc_in_tick) begin
          d.cnt = q.cnt + 22'h00_0001;
        end
        if (bod_trip) begin
          d.state = RTSEQ_S_HOLD;
        end else if (osc_in_tick && q.cnt == OST_LAST) begin
          d.ost_pend = 1'b0;
          d.state = RTSEQ_S_WAITCLR;
        end
      end
      RTSEQ_S_WAITCLR: begin
        // delays already spent; clear release starts at once
        d.powerup_delay_timer_pend = 1'b0;
        d.ost_pend = 1'b0;
        d.in_bod = 1'b0;
        if (bod_trip) begin
          d.state = RTSEQ_S_HOLD;
        end else if (!clr_active) begin
          d.state = RTSEQ_S_RUN;
          d.core_rst = 1'b0;
        end
      end
      RTSEQ_S_RUN: begin
        // power-on logic alone never resets here on supply fall
        d.core_rst = 1'b0;
        if (bod_trip) begin
          d.state = RTSEQ_S_HOLD;
          d.core_rst = 1'b1;
          d.regs_load = 1'b1;
          d.cause = RTSEQ_C_BOD;
          d.powerup_delay_timer_pend = 1'b1;
          d.ost_pend = 1'b0;
          d.flags.bod_flag_n = `RTSEQ_FLAG_CLR;
          d.flags.timeout_flag = `RTSEQ_FLAG_SET;
          d.flags.powerdown_flag = `RTSEQ_FLAG_SET;
        end else if (wdt_any && core_sleeping) begin
          // wake resumes: registers kept, only crystal start-up applies
          d.state = RTSEQ_S_HOLD;
          d.core_rst = 1'b1;
          d.wake_pulse = 1'b1;
          d.cause = RTSEQ_C_WDT_WAKE;
          d.ost_pend = 1'b1;
          d.flags.timeout_flag = `RTSEQ_FLAG_CLR;
          d.flags.powerdown_flag = `RTSEQ_FLAG_CLR;
        end else if (wdt_any) begin
          // pin stays input: ext_clear_pin_oe held low
          d.state = RTSEQ_S_HOLD;
          d.core_rst = 1'b1;
          d.regs_load = 1'b1;
          d.cause = RTSEQ_C_WDT_RUN;
          d.flags.timeout_flag = `RTSEQ_FLAG_CLR;
        end else if (clr_active) begin
          d.state = RTSEQ_S_WAITCLR;
          d.core_rst = 1'b1;
          d.regs_load = 1'b1;
          if (core_sleeping) begin
            d.cause = RTSEQ_C_CLR_SLEEP;
            d.flags.timeout_flag = `RTSEQ_FLAG_SET;
            d.flags.powerdown_flag = `RTSEQ_FLAG_CLR;
          end else begin
            d.cause = RTSEQ_C_CLR_RUN;
          end
        end
      end
      default: begin
        d.state = RTSEQ_S_HOLD;
        d.core_rst = 1'b1;
      end
    endcase

    // watchdog time-out that hits while the core sleeps but is mid reset
    if (q.state != RTSEQ_S_RUN && wdt_any && q.cause == RTSEQ_C_CLR_SLEEP) begin
      d.cause = RTSEQ_C_WDT_SLEEP;
    end

    // first cycle after power-on marks the por cause
    if (!q.por_done) begin
      d.cause = RTSEQ_C_POR;
      d.regs_load = 1'b1;
      d.por_done = 1'b1;
    end

    // software sets; a hardware clear in the same cycle wins
    if (sw_set_por_flag && q.por_done) begin
      d.flags.por_flag_n = `RTSEQ_FLAG_SET;
    end
    if (sw_set_bod_flag && !(q.state == RTSEQ_S_RUN && bod_trip)) begin
      d.flags.bod_flag_n = `RTSEQ_FLAG_SET;
    end
  end

  // single register for all state; rst is the power-on event
  always_ff @(posedge clk) begin
    if (rst) begin
      q.state <= RTSEQ_S_HOLD;
      q.cnt <= 22'h00_0000;
      q.clr_filt <= 4'h0;
      q.clr_low <= 1'b0;
      q.bod_cnt <= 6'h00;
      q.in_bod <= 1'b0;
      q.core_rst <= 1'b1;
      q.regs_load <= 1'b1;
      q.wake_pulse <= 1'b0;
      q.cause <= RTSEQ_C_POR;
      // bod flag unknown at power-on; keep it set as a defined value
      q.flags <= {`RTSEQ_FLAG_SET, `RTSEQ_FLAG_SET, `RTSEQ_FLAG_CLR, `RTSEQ_FLAG_SET};
      q.div <= 2'h0;
      q.clk_out <= 1'b0;
      q.clk_out_oe <= 1'b0;
      q.por_done <= 1'b0;
      q.powerup_delay_timer_pend <= 1'b1;
      q.ost_pend <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops, clear pin enable tied low; register contents live in the core
  assign core_reset = q.core_rst;
  assign regs_reset_load = q.regs_load;
  assign wake_from_sleep = q.wake_pulse;
  assign reset_cause = q.cause;
  assign status_flags = q.flags;
  assign clock_out_pin = q.clk_out;
  assign clock_out_pin_oe = q.clk_out_oe;
  assign ext_clear_pin_oe = 1'b0;
endmodule : rtseq_top

// file: rtseq_consts.svh
`ifndef RTSEQ_CONSTS_SVH
`define RTSEQ_CONSTS_SVH
// clock and delay figures
`define RTSEQ_CLK_HZ 40000000
`define RTSEQ_POWERUP_DELAY_TIMER_MS 72
`define RTSEQ_OST_CYCLES 1024
// glitch filter on the clear pin, in system clocks
`define RTSEQ_CLR_FILT_CYC 8
// brown-out minimum low duration, in system clocks
`define RTSEQ_BOD_MIN_CYC 40
// oscillator select codes
`define RTSEQ_OSC_LP 3'h0
`define RTSEQ_OSC_XT 3'h1
`define RTSEQ_OSC_HS 3'h2
`define RTSEQ_OSC_EC 3'h3
`define RTSEQ_OSC_INT_IO 3'h4
`define RTSEQ_OSC_INT_CK 3'h5
`define RTSEQ_OSC_RC_IO 3'h6
`define RTSEQ_OSC_RC_CK 3'h7
// flag values loaded by resets
`define RTSEQ_FLAG_SET 1'b1
`define RTSEQ_FLAG_CLR 1'b0
`endif

// file: rtseq_pkg.sv
package rtseq_pkg;
  typedef enum logic [4:0] {
    RTSEQ_S_HOLD = 5'b00001,
    RTSEQ_S_POWERUP_DELAY_TIMER = 5'b00010,
    RTSEQ_S_OST = 5'b00100,
    RTSEQ_S_WAITCLR = 5'b01000,
    RTSEQ_S_RUN = 5'b10000
  } rtseq_state_t;

  // reset cause codes reported to the core
  typedef enum logic [2:0] {
    RTSEQ_C_NONE = 3'h0,
    RTSEQ_C_POR = 3'h1,
    RTSEQ_C_WDT_RUN = 3'h2,
    RTSEQ_C_WDT_SLEEP = 3'h3,
    RTSEQ_C_CLR_RUN = 3'h4,
    RTSEQ_C_CLR_SLEEP = 3'h5,
    RTSEQ_C_BOD = 3'h6,
    RTSEQ_C_WDT_WAKE = 3'h7
  } rtseq_cause_t;

  typedef struct packed {
    logic [2:0] osc_mode;
    logic ext_clear_pin_select;
    logic powerup_delay_off_cfg;
    logic brownout_enable_cfg;
  } rtseq_cfg_t;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic por_flag_n;
    logic bod_flag_n;
  } rtseq_flags_t;

  typedef struct packed {
    rtseq_state_t state;
    logic [21:0] cnt;
    logic [3:0] clr_filt;
    logic clr_low;
    logic [5:0] bod_cnt;
    logic in_bod;
    logic core_rst;
    logic regs_load;
    logic wake_pulse;
    rtseq_cause_t cause;
    rtseq_flags_t flags;
    logic [1:0] div;
    logic clk_out;
    logic clk_out_oe;
    logic por_done;
    logic powerup_delay_timer_pend;
    logic ost_pend;
  } rtseq_st_t;
endpackage : rtseq_pkg

// file: rtseq_checker.sv
`timescale 1ns/100ps
`include "rtseq_consts.svh"
module rtseq_checker import rtseq_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // causes
  input wire logic brownout_detect,
  input wire logic ext_clear_pin,
  input wire logic watchdog_timer,
  input wire logic core_sleeping,
  input wire logic supply_ok,
  input wire logic sw_set_por_flag,
  input rtseq_pkg::rtseq_cfg_t cfg,
  // results
  input wire logic core_reset,
  input wire logic regs_reset_load,
  input wire logic wake_from_sleep,
  input rtseq_pkg::rtseq_cause_t reset_cause,
  input rtseq_pkg::rtseq_flags_t status_flags,
  input wire logic clock_out_pin,
  input wire logic clock_out_pin_oe,
  input wire logic ext_clear_pin_oe
);
  logic [6:0] bod_q;
  logic [6:0] clr_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // run lengths of low supply and clear low; saturate so they never wrap
  always_ff @(posedge clk) begin
    bod_q <= (rst || !(brownout_detect && cfg.brownout_enable_cfg)) ? 7'h00 :
      (bod_q[6] ? bod_q : bod_q + 7'h01);
    clr_q <= (rst || ext_clear_pin || !cfg.ext_clear_pin_select) ? 7'h00 :
      (clr_q[6] ? clr_q : clr_q + 7'h01);
  end
  AST_PIN_INPUT: assert property (ext_clear_pin_oe == 1'b0)
    else $error("clear pin driven");
  AST_REL_SUPPLY: assert property ($fell(core_reset) |-> $past(supply_ok))
    else $error("released without supply");
  AST_QUIET: assert property (!core_reset && !watchdog_timer && !$past(watchdog_timer)
    && !$past(watchdog_timer, 2) && bod_q < 7'h1e && clr_q < 7'h05 |=> !core_reset)
    else $error("reset without cause");
  AST_CLR_RST: assert property (clr_q == 7'h0c |-> core_reset)
    else $error("long clear ignored");
  AST_BOD_RST: assert property (bod_q == 7'h2e |-> core_reset)
    else $error("brown-out ignored");
  AST_WDT_RUN: assert property (!core_reset && !core_sleeping && watchdog_timer
    |-> ##[1:3] (core_reset && reset_cause == RTSEQ_C_WDT_RUN))
    else $error("watchdog reset missing");
  AST_WAKE: assert property (wake_from_sleep |-> (!regs_reset_load) [*2])
    else $error("wake loaded reset state");
  AST_CLOCK_OUT_PIN: assert property (clock_out_pin_oe && $past(clock_out_pin_oe, 4)
    |-> clock_out_pin == $past(clock_out_pin, 4) && clock_out_pin != $past(clock_out_pin, 2))
    else $error("clock out not quarter rate");
  AST_OE_MODE: assert property (clock_out_pin_oe
    |-> cfg.osc_mode inside {`RTSEQ_OSC_INT_CK, `RTSEQ_OSC_RC_CK})
    else $error("clock out in wrong mode");
  AST_POR_FLAG: assert property ($changed(status_flags.por_flag_n)
    |-> $past(sw_set_por_flag) || $past(sw_set_por_flag, 2))
    else $error("power-on flag moved");
  // main scenarios reached
  cover property ($fell(core_reset));
  cover property (wake_from_sleep);
  cover property (clock_out_pin_oe);
endmodule : rtseq_checker
bind rtseq_top rtseq_checker rtseq_checker_i (.clk, .rst, .brownout_detect, .ext_clear_pin,
  .watchdog_timer, .core_sleeping, .supply_ok, .sw_set_por_flag, .cfg, .core_reset,
  .regs_reset_load, .wake_from_sleep, .reset_cause, .status_flags, .clock_out_pin,
  .clock_out_pin_oe, .ext_clear_pin_oe);

// file: rtseq_partner.sv
`timescale 1ns/100ps
module rtseq_partner (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic want_up,
  input wire logic want_dip,
  input wire logic want_clr,
  // to the sequencer
  output logic supply_ok,
  output logic brownout_detect,
  output logic ext_clear_pin,
  output logic osc_in_tick
);
  // a dip is below the release level as well
  assign supply_ok = want_up && !want_dip;
  assign brownout_detect = want_dip;
  // board pull-up keeps the pin high, the chip has none
  assign ext_clear_pin = !want_clr;
  // crystal pulse every second clock, moved off the sampling edge
  initial osc_in_tick = 1'b0;
  always @(negedge clk) osc_in_tick <= !osc_in_tick;
endmodule : rtseq_partner

// file: rtseq_bench.sv
`timescale 1ns/100ps
module rtseq_bench;
  import rtseq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic want_up = 1'b1;
  logic want_dip = 1'b0;
  logic want_clr = 1'b0;
  logic watchdog_timer = 1'b0;
  logic core_sleeping = 1'b0;
  logic sw_set_por_flag = 1'b0;
  logic sw_set_bod_flag = 1'b0;
  rtseq_cfg_t cfg = '0;
  logic supply_ok, brownout_detect, ext_clear_pin, osc_in_tick;
  logic core_reset, regs_reset_load, wake_from_sleep;
  logic clock_out_pin, clock_out_pin_oe, ext_clear_pin_oe;
  rtseq_cause_t reset_cause;
  rtseq_flags_t status_flags;
  int fails = 0;
  int comparisons = 0;
  int n;
  // {mode, timer off, expected release cycles}; timer 50, crystal 1024 ticks of 2
  logic [15:0] rows [9] = '{16'h7000, 16'h6032, 16'h8032, 16'hf000, 16'h3800,
    16'h4832, 16'h1800, 16'ha032, 16'hd000};
  always #12.5 clk = ~clk;
  rtseq_partner rtseq_partner_i (.clk, .want_up, .want_dip, .want_clr, .supply_ok,
    .brownout_detect, .ext_clear_pin, .osc_in_tick);
  rtseq_top #(.POWERUP_DELAY_TIMER_CYCLES(50)) rtseq_top_i (.clk, .rst, .supply_ok, .brownout_detect,
    .ext_clear_pin, .osc_in_tick, .watchdog_timer, .core_sleeping, .cfg, .sw_set_por_flag,
    .sw_set_bod_flag, .core_reset, .regs_reset_load, .wake_from_sleep, .reset_cause,
    .status_flags, .clock_out_pin, .clock_out_pin_oe, .ext_clear_pin_oe);
  task automatic summarize();
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // window compare; four-state safe so unknowns fail
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g,
      input int s = 0);
    comparisons++;
    if ((g >= e && g <= e + s) !== 1'b1) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", w, e, g);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step
  // bounded wait for the core reset level, cycles left in n
  task automatic till(input logic v);
    n = 0;
    while (core_reset !== v) begin
      step(1);
      n++;
      if (n > 3000) begin
        fails++;
        summarize();
      end
    end
  endtask : till
  // power-on with clear held low for h cycles after it
  task automatic por(input rtseq_cfg_t c, input int h);
    rst = 1'b1;
    cfg = c;
    want_clr = h != 0;
    step(8);
    rst = 1'b0;
    step(h);
    want_clr = 1'b0;
    till(1'b0);
  endtask : por
  initial begin
    for (int i = 0; i < 9; i++) begin
      por({rows[i][15:13], 1'b1, rows[i][12], !rows[i][12]}, 0);
      chk("release", rows[i][11:0], n, 8);
      chk("cause", RTSEQ_C_POR, reset_cause);
      chk("flags", 3'h6, status_flags[3:1]);
      chk("clk oe", rows[i][15:13] inside {3'h5, 3'h7}, clock_out_pin_oe);
    end
    // awkward cases: clear held past the delays, then run-time causes
    por(6'h1d, 200);
    chk("clr hold", 0, n, 12);
    sw_set_por_flag = 1'b1;
    step(1);
    sw_set_por_flag = 1'b0;
    step(2);
    chk("por flag", 1, status_flags.por_flag_n);
    want_clr = 1'b1;
    step(5);
    want_clr = 1'b0;
    step(4);
    chk("glitch", 0, core_reset);
    want_clr = 1'b1;
    step(20);
    chk("clr cause", RTSEQ_C_CLR_RUN, reset_cause);
    chk("clr to", 1, status_flags.timeout_flag);
    step(80);
    want_clr = 1'b0;
    till(1'b0);
    chk("clr rel", 0, n, 12);
    watchdog_timer = 1'b1;
    step(1);
    watchdog_timer = 1'b0;
    step(4);
    chk("wdt cause", RTSEQ_C_WDT_RUN, reset_cause);
    chk("wdt to", 0, status_flags.timeout_flag);
    till(1'b0);
    chk("wdt rel", 0, n, 6);
    // watchdog wake from sleep keeps register contents
    core_sleeping = 1'b1;
    watchdog_timer = 1'b1;
    step(1);
    watchdog_timer = 1'b0;
    for (n = 0; n < 20 && wake_from_sleep !== 1'b1; n++) step(1);
    chk("wake", 1, wake_from_sleep);
    chk("wake load", 0, regs_reset_load);
    step(2);
    chk("wake flags", 0, status_flags[3:2]);
    core_sleeping = 1'b0;
    till(1'b0);
    core_sleeping = 1'b1;
    want_clr = 1'b1;
    step(20);
    chk("slp cause", RTSEQ_C_CLR_SLEEP, reset_cause);
    chk("slp flags", 2, status_flags[3:2]);
    watchdog_timer = 1'b1;
    step(1);
    watchdog_timer = 1'b0;
    step(1);
    chk("wdt slp cause", RTSEQ_C_WDT_SLEEP, reset_cause);
    core_sleeping = 1'b0;
    want_clr = 1'b0;
    till(1'b0);
    // short dip ignored, long dip resets, dip inside the timer restarts it
    want_dip = 1'b1;
    step(20);
    want_dip = 1'b0;
    step(2);
    chk("dip", 0, core_reset);
    want_dip = 1'b1;
    step(60);
    chk("bod cause", RTSEQ_C_BOD, reset_cause);
    chk("bod flags", 2, status_flags[1:0]);
    step(100);
    chk("bod hold", 1, core_reset);
    want_dip = 1'b0;
    step(20);
    want_dip = 1'b1;
    step(60);
    want_dip = 1'b0;
    till(1'b0);
    chk("powerup_delay_timer again", 50, n, 8);
    // internal clear, timer and brown-out off: nothing may reset
    por(6'h1a, 0);
    chk("ec no delay", 0, n, 6);
    want_dip = 1'b1;
    want_up = 1'b0;
    want_clr = 1'b1;
    step(60);
    chk("no reset", 0, core_reset);
    summarize();
  end
endmodule : rtseq_bench
